//--- hw/ser_pkg.sv
// Shared constants, command codes and carrier structs for the status event registers.
// Assumes one device clock and that the command interpreter drives the command port.
// Notes on behaviour
// - Event bits latch until explicitly cleared.
// - Event query or clear-status clears event bits.
// - Instrument reset and device clear keep events.
// - Summary is OR of enabled event bits.
// - Masks readable, writable; clear-status keeps masks.
// - Values are binary-weighted sums of bits.
// - Questionable bits 0/1 on voltage/current unregulated.
// - Questionable bit 4 on fan overtemperature.
// - Questionable bit 9 on overvoltage trip.
// - Questionable mask clears at power-up reset or by writing zero.
// - Standard summary goes to status bit 5.
// - Standard error bits push error queue entries.
// - Standard bit 0 on operation complete.
// - Standard bit 2 on query errors.
// - Standard bit 3 on self-test/calibration error.
// - Standard bit 4 on execution error.
// - Standard bit 5 on command syntax error.
// - Standard bit 7 set after power cycle.
// - Standard mask cleared at power-up if setting 1.
// - Questionable summary bit 3, standard summary bit 5.
package ser_pkg;

  localparam int unsigned QUESTIONABLE_SUMMARY_BIT_W = 16;
  localparam int unsigned STD_W  = 8;
  localparam int unsigned DATA_W = 16;

  localparam int unsigned QUESTIONABLE_SUMMARY_BIT_VOLT_BIT = 0;
  localparam int unsigned QUESTIONABLE_SUMMARY_BIT_CURR_BIT = 1;
  localparam int unsigned QUESTIONABLE_SUMMARY_BIT_TEMP_BIT = 4;
  localparam int unsigned QUESTIONABLE_SUMMARY_BIT_OVP_BIT  = 9;
  localparam logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] QUESTIONABLE_SUMMARY_BIT_USED_MASK = 16'h0213;

  localparam int unsigned STD_OPC_BIT = 0;
  localparam int unsigned STD_QYE_BIT = 2;
  localparam int unsigned STD_DDE_BIT = 3;
  localparam int unsigned STD_EXE_BIT = 4;
  localparam int unsigned STD_CME_BIT = 5;
  localparam int unsigned STD_PWR_BIT = 7;
  localparam logic [STD_W-1:0] STD_USED_MASK = 8'hbd;

  localparam int unsigned STB_QUESTIONABLE_SUMMARY_BIT_BIT = 3;
  localparam int unsigned STB_STD_BIT  = 5;

  localparam logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] QUESTIONABLE_SUMMARY_BIT_EV_RESET   = 16'h0000;
  localparam logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] QUESTIONABLE_SUMMARY_BIT_MASK_RESET = 16'h0000;
  localparam logic [STD_W-1:0]  STD_EV_RESET    = 8'h00;
  localparam logic [STD_W-1:0]  STD_MASK_RESET  = 8'h00;
  localparam logic              PSC_RESET       = 1'b1;
  localparam int unsigned       SYNC_STAGES     = 2;

  typedef enum logic [3:0] {
    SER_CMD_NOP       = 4'h0,
    SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ  = 4'h1,
    SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENQ  = 4'h2,
    SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENW  = 4'h3,
    SER_CMD_STD_EVQ   = 4'h4,
    SER_CMD_STD_ENQ   = 4'h5,
    SER_CMD_STD_ENW   = 4'h6,
    SER_CMD_CLS       = 4'h7,
    SER_CMD_RST       = 4'h8,
    SER_CMD_DEV_CLR   = 4'h9,
    SER_CMD_STB_Q     = 4'ha,
    SER_CMD_PSC_W     = 4'hb,
    SER_CMD_PSC_Q     = 4'hc
  } ser_cmd_e;

  typedef struct packed {
    logic              valid;
    ser_cmd_e          op;
    logic [DATA_W-1:0] wdata;
  } ser_cmd_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } ser_rsp_s;

  typedef struct packed {
    logic volt_unreg;
    logic curr_unreg;
    logic fan_overtemp;
    logic ovp_tripped;
  } ser_qcond_s;

  typedef struct packed {
    logic operation_complete_flag;
    logic obuf_empty_read;
    logic line_before_query_read;
    logic buffers_full;
    logic device_error_flag;
    logic execution_error_flag;
    logic command_error_flag;
  } ser_std_ev_s;

  typedef struct packed {
    logic push;
    logic query_error_flag;
    logic device_error_flag;
    logic execution_error_flag;
    logic command_error_flag;
  } ser_err_s;

endpackage

//--- hw/ser_event_group.sv
// One latched event register with its enable mask and registered summary bit.
// Assumes set, clear and write strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ser_event_group
  import ser_pkg::*;
#(
  parameter int unsigned       W          = 8,
  parameter logic [W-1:0]      USED       = '1,
  parameter logic [W-1:0]      EV_RESET   = '0,
  parameter logic [W-1:0]      MASK_RESET = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clear_ev,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_wdata,
  output logic      [W-1:0] ev_q,
  output logic      [W-1:0] mask_q,
  output logic              summary_q
);

  // Refuses widths that do not fit the response word.
  if (W < 1 || W > DATA_W) begin
    $error("ser_event_group width out of range");
  end

  typedef struct packed {
    logic [W-1:0] ev;
    logic [W-1:0] mask;
    logic         summary;
  } ser_grp_s;

  ser_grp_s st_q;
  ser_grp_s st_d;

  always_comb begin
    st_d = st_q;
    // Set wins over a clear in the same cycle; bits stay set otherwise.
    st_d.ev = ((clear_ev ? '0 : st_q.ev) | set_bits) & USED;
    if (mask_we) begin
      st_d.mask = mask_wdata & USED;
    end
    st_d.summary = |(st_d.ev & st_d.mask);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{ev: EV_RESET, mask: MASK_RESET, summary: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign ev_q      = st_q.ev;
  assign mask_q    = st_q.mask;
  assign summary_q = st_q.summary;

endmodule
`default_nettype wire

//--- hw/ser_status_top.sv
// Status event registers: questionable and standard groups with masks and status byte bits.
// Assumes the command interpreter drives one command per cycle and that the saved
// power-on-clear setting and saved standard mask are stable from reset release.
`timescale 1ns/1ps
`default_nettype none
module ser_status_top
  import ser_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire ser_qcond_s  qcond_pin,
  input  wire ser_std_ev_s std_ev,
  input  wire ser_cmd_s    cmd,
  input  wire logic        psc_saved,
  input  wire logic [STD_W-1:0] std_mask_saved,
  output logic             cmd_ready,
  output ser_rsp_s         rsp,
  output ser_err_s         err,
  output logic [STD_W-1:0] status_byte,
  output logic             power_on_clear_setting,
  output logic [STD_W-1:0] std_mask_out
);

  typedef enum logic [1:0] {
    SER_ST_BOOT  = 2'b00,
    SER_ST_LOAD  = 2'b01,
    SER_ST_RUN   = 2'b10
  } ser_phase_e;

  typedef struct packed {
    ser_phase_e  phase;
    ser_qcond_s  sync1;
    ser_qcond_s  sync2;
    logic        psc;
    logic        ready;
    ser_rsp_s    rsp;
    ser_err_s    err;
  } ser_top_s;

  ser_top_s st_q;
  ser_top_s st_d;

  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] questionable_summary_bit_ev;
  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] questionable_summary_bit_mask;
  logic              questionable_summary_bit_sum;
  logic [STD_W-1:0]  std_ev_bits;
  logic [STD_W-1:0]  std_mask;
  logic              std_sum;

  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] questionable_summary_bit_set;
  logic [STD_W-1:0]  std_set;
  logic              take;
  logic              cls;
  logic              questionable_summary_bit_clr;
  logic              std_clr;
  logic              questionable_summary_bit_mask_we;
  logic              std_mask_we;
  logic [STD_W-1:0]  std_mask_wdata;
  logic              qye_any;
  logic              pwr_set;

  assign take = st_q.ready && cmd.valid;
  assign cls  = take && (cmd.op == SER_CMD_CLS);

  // Instrument reset and device clear are acknowledged but touch no event bit.
  assign questionable_summary_bit_clr = cls || (take && (cmd.op == SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ));
  assign std_clr  = cls || (take && (cmd.op == SER_CMD_STD_EVQ));

  assign qye_any = std_ev.obuf_empty_read || std_ev.line_before_query_read
                   || std_ev.buffers_full;
  assign pwr_set = (st_q.phase == SER_ST_LOAD);

  always_comb begin
    questionable_summary_bit_set                = '0;
    questionable_summary_bit_set[QUESTIONABLE_SUMMARY_BIT_VOLT_BIT] = st_q.sync2.volt_unreg;
    questionable_summary_bit_set[QUESTIONABLE_SUMMARY_BIT_CURR_BIT] = st_q.sync2.curr_unreg;
    questionable_summary_bit_set[QUESTIONABLE_SUMMARY_BIT_TEMP_BIT] = st_q.sync2.fan_overtemp;
    questionable_summary_bit_set[QUESTIONABLE_SUMMARY_BIT_OVP_BIT]  = st_q.sync2.ovp_tripped;
  end

  always_comb begin
    std_set              = '0;
    std_set[STD_OPC_BIT] = std_ev.operation_complete_flag;
    std_set[STD_QYE_BIT] = qye_any;
    std_set[STD_DDE_BIT] = std_ev.device_error_flag;
    std_set[STD_EXE_BIT] = std_ev.execution_error_flag;
    std_set[STD_CME_BIT] = std_ev.command_error_flag;
    std_set[STD_PWR_BIT] = pwr_set;
  end

  assign questionable_summary_bit_mask_we = take && (cmd.op == SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENW);

  // The standard mask is loaded once at power-up from the saved copy or cleared.
  always_comb begin
    std_mask_we    = 1'b0;
    std_mask_wdata = std_mask;
    if (st_q.phase == SER_ST_LOAD) begin
      std_mask_we    = 1'b1;
      std_mask_wdata = psc_saved ? STD_MASK_RESET : std_mask_saved;
    end else if (take && (cmd.op == SER_CMD_STD_ENW)) begin
      std_mask_we    = 1'b1;
      std_mask_wdata = cmd.wdata[STD_W-1:0];
    end
  end

  ser_event_group #(
    .W          (QUESTIONABLE_SUMMARY_BIT_W),
    .USED       (QUESTIONABLE_SUMMARY_BIT_USED_MASK),
    .EV_RESET   (QUESTIONABLE_SUMMARY_BIT_EV_RESET),
    .MASK_RESET (QUESTIONABLE_SUMMARY_BIT_MASK_RESET)
  ) u_questionable_summary_bit (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .set_bits   (questionable_summary_bit_set),
    .clear_ev   (questionable_summary_bit_clr),
    .mask_we    (questionable_summary_bit_mask_we),
    .mask_wdata (cmd.wdata[QUESTIONABLE_SUMMARY_BIT_W-1:0]),
    .ev_q       (questionable_summary_bit_ev),
    .mask_q     (questionable_summary_bit_mask),
    .summary_q  (questionable_summary_bit_sum)
  );

  ser_event_group #(
    .W          (STD_W),
    .USED       (STD_USED_MASK),
    .EV_RESET   (STD_EV_RESET),
    .MASK_RESET (STD_MASK_RESET)
  ) u_std (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .set_bits   (std_set),
    .clear_ev   (std_clr),
    .mask_we    (std_mask_we),
    .mask_wdata (std_mask_wdata),
    .ev_q       (std_ev_bits),
    .mask_q     (std_mask),
    .summary_q  (std_sum)
  );

  always_comb begin
    st_d       = st_q;
    st_d.sync1 = qcond_pin;
    st_d.sync2 = st_q.sync1;

    unique case (st_q.phase)
      SER_ST_BOOT: begin
        st_d.phase = SER_ST_LOAD;
        st_d.psc   = psc_saved;
      end
      SER_ST_LOAD: begin
        st_d.phase = SER_ST_RUN;
        st_d.ready = 1'b1;
      end
      SER_ST_RUN: begin
        st_d.phase = SER_ST_RUN;
      end
      default: begin
        st_d.phase = SER_ST_BOOT;
        st_d.ready = 1'b0;
      end
    endcase

    // Answers carry the register contents before any clear in the same cycle.
    st_d.rsp.valid = take;
    st_d.rsp.data  = '0;
    if (take) begin
      unique case (cmd.op)
        SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ: st_d.rsp.data = questionable_summary_bit_ev;
        SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENQ: st_d.rsp.data = questionable_summary_bit_mask;
        SER_CMD_STD_EVQ:  st_d.rsp.data = {8'h00, std_ev_bits};
        SER_CMD_STD_ENQ:  st_d.rsp.data = {8'h00, std_mask};
        SER_CMD_STB_Q:    st_d.rsp.data = {8'h00, status_byte};
        SER_CMD_PSC_Q:    st_d.rsp.data = {15'h0000, st_q.psc};
        SER_CMD_PSC_W:    st_d.psc = cmd.wdata[0];
        default:          st_d.rsp.data = '0;
      endcase
    end

    // One error queue entry per cycle in which an error bit is raised.
    st_d.err.query_error_flag     = qye_any;
    st_d.err.device_error_flag    = std_ev.device_error_flag;
    st_d.err.execution_error_flag = std_ev.execution_error_flag;
    st_d.err.command_error_flag   = std_ev.command_error_flag;
    st_d.err.push = qye_any || std_ev.device_error_flag
                    || std_ev.execution_error_flag || std_ev.command_error_flag;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{phase: SER_ST_BOOT, sync1: '0, sync2: '0, psc: PSC_RESET,
                ready: 1'b0, rsp: '0, err: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Summary bits come from registers that track the masked event bits each cycle.
  always_comb begin
    status_byte               = '0;
    status_byte[STB_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit_sum;
    status_byte[STB_STD_BIT]  = std_sum;
  end

  assign cmd_ready              = st_q.ready;
  assign rsp                    = st_q.rsp;
  assign err                    = st_q.err;
  assign power_on_clear_setting = st_q.psc;
  assign std_mask_out           = std_mask;

endmodule
`default_nettype wire

//--- sim/ser_status_checker.sv
// Concurrent checks on the ports of the status event register top module.
// Assumes the command port contract of the top module and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ser_status_checker
  import ser_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             nrst,
  input wire ser_qcond_s       qcond_pin,
  input wire ser_std_ev_s      std_ev,
  input wire ser_cmd_s         cmd,
  input wire logic             psc_saved,
  input wire logic [STD_W-1:0] std_mask_saved,
  input wire logic             cmd_ready,
  input wire ser_rsp_s         rsp,
  input wire ser_err_s         err,
  input wire logic [STD_W-1:0] status_byte,
  input wire logic             power_on_clear_setting,
  input wire logic [STD_W-1:0] std_mask_out
);
  wire logic       taken = cmd.valid && cmd_ready;
  wire logic [7:0] wlow  = cmd.wdata[7:0];
  wire logic       errin = std_ev.obuf_empty_read || std_ev.line_before_query_read
                        || std_ev.buffers_full || std_ev.device_error_flag
                        || std_ev.execution_error_flag || std_ev.command_error_flag;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_STB_UNUSED: assert property ((status_byte & 8'hd7) == 8'h00)
    else $error("status byte unused bit set");
  AST_RSP_NEXT: assert property (taken |=> rsp.valid)
    else $error("no response after command");
  AST_RSP_CAUSE: assert property (rsp.valid |-> $past(taken))
    else $error("response without command");
  AST_STD_WIDTH: assert property (rsp.valid && ($past(cmd.op) inside {SER_CMD_STD_EVQ,
    SER_CMD_STD_ENQ}) |-> (rsp.data & 16'hff42) == 16'h0000) else $error("std unused bit read");
  AST_QUESTIONABLE_SUMMARY_BIT_WIDTH: assert property (rsp.valid && ($past(cmd.op) inside {SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ,
    SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENQ}) |-> (rsp.data & 16'hfdec) == 16'h0000) else $error("questionable_summary_bit unused bit read");
  AST_STD_QRY_CLR: assert property (taken && cmd.op == SER_CMD_STD_EVQ && std_ev == '0
    |=> !status_byte[STB_STD_BIT]) else $error("std query left summary set");
  AST_QUESTIONABLE_SUMMARY_BIT_CLS: assert property ((qcond_pin == '0)[*3] ##0 (taken && cmd.op == SER_CMD_CLS)
    |=> !status_byte[STB_QUESTIONABLE_SUMMARY_BIT_BIT]) else $error("clear left questionable_summary_bit summary set");
  AST_STD_SET: assert property (cmd_ready && !cmd.valid && std_ev.command_error_flag
    && std_mask_out[STD_CME_BIT] |=> status_byte[STB_STD_BIT]) else $error("std summary not set");
  AST_STD_HOLD: assert property (status_byte[STB_STD_BIT] && !(taken && (cmd.op inside
    {SER_CMD_STD_EVQ, SER_CMD_CLS, SER_CMD_STD_ENW})) |=> status_byte[STB_STD_BIT])
    else $error("std summary dropped");
  AST_MASK_WR: assert property (taken && cmd.op == SER_CMD_STD_ENW
    |=> std_mask_out == ($past(wlow) & STD_USED_MASK)) else $error("std mask write lost");
  AST_ERR_PUSH: assert property (cmd_ready && std_ev.execution_error_flag
    |=> err.push && err.execution_error_flag) else $error("no error entry");
  AST_ERR_CAUSE: assert property (err.push |-> $past(errin))
    else $error("error entry without cause");
endmodule
bind ser_status_top ser_status_checker u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .qcond_pin(qcond_pin), .std_ev(std_ev), .cmd(cmd),
  .psc_saved(psc_saved), .std_mask_saved(std_mask_saved), .cmd_ready(cmd_ready),
  .rsp(rsp), .err(err), .status_byte(status_byte),
  .power_on_clear_setting(power_on_clear_setting), .std_mask_out(std_mask_out)
);
`default_nettype wire

//--- sim/ser_host_model.sv
// Command interpreter model that issues one command and returns its response.
// Assumes it is called at a falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ser_host_model
  import ser_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     cmd_ready,
  input  wire ser_rsp_s rsp,
  output var ser_cmd_s  cmd
);
  initial cmd = '0;
  task automatic issue(input ser_cmd_e op, input logic [15:0] wd, output ser_rsp_s r);
    int n;
    n = 0;
    cmd <= '{1'b1, op, wd};
    while (cmd_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    r = rsp;
    cmd <= '{1'b0, SER_CMD_NOP, ~wd};
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/status_event_registers_tb.sv
// Testbench for the status event registers top module.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module status_event_registers_tb
  import ser_pkg::*;
;
  logic             ref_clk;
  logic             nrst;
  logic             psc_saved;
  logic             cmd_ready;
  logic             power_on_clear_setting;
  logic [STD_W-1:0] std_mask_saved;
  logic [STD_W-1:0] status_byte;
  logic [STD_W-1:0] std_mask_out;
  ser_qcond_s       qcond_pin;
  ser_std_ev_s      std_ev;
  ser_cmd_s         cmd;
  ser_rsp_s         rsp;
  ser_rsp_s         r;
  ser_err_s         err;
  int               n_fail = 0;
  int               total_checks = 0;
  logic [15:0]      std_w [7] = '{16'h1, 16'h4, 16'h4, 16'h4, 16'h8, 16'h10, 16'h20};
  logic [15:0]      questionable_summary_bit_w [4] = '{16'h1, 16'h2, 16'h10, 16'h200};
  logic [4:0]       err_w [7] = '{5'h00, 5'h18, 5'h18, 5'h18, 5'h14, 5'h12, 5'h11};
  ser_status_top u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .qcond_pin(qcond_pin), .std_ev(std_ev), .cmd(cmd),
    .psc_saved(psc_saved), .std_mask_saved(std_mask_saved), .cmd_ready(cmd_ready),
    .rsp(rsp), .err(err), .status_byte(status_byte),
    .power_on_clear_setting(power_on_clear_setting), .std_mask_out(std_mask_out)
  );
  ser_host_model u_host (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .rsp(rsp), .cmd(cmd));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_cmd(input ser_cmd_e op, input logic [15:0] wd, input logic [15:0] exp);
    u_host.issue(op, wd, r);
    `CHK({r.valid, r.data}, {1'b1, exp})
  endtask
  task automatic do_reset(input logic p, input logic [7:0] m);
    nrst = 1'b0;
    psc_saved = p;
    std_mask_saved = m;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic pin_pulse(input logic [3:0] v);
    qcond_pin = v;
    repeat (4) @(negedge ref_clk);
    qcond_pin = '0;
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    results();
  end
  initial begin
    qcond_pin = '0;
    std_ev = '0;
    do_reset(1'b1, 8'hff);
    do_cmd(SER_CMD_STD_ENQ, 16'h0, 16'h0);
    do_cmd(SER_CMD_PSC_Q, 16'h0, 16'h1);
    `CHK(power_on_clear_setting, 1'b1)
    do_cmd(SER_CMD_STD_EVQ, 16'h0, 16'h80);
    do_cmd(SER_CMD_STD_EVQ, 16'h0, 16'h0);
    do_cmd(SER_CMD_STD_ENW, 16'hffff, 16'h0);
    do_cmd(SER_CMD_STD_ENQ, 16'h0, 16'hbd);
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENW, 16'hffff, 16'h0);
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENQ, 16'h0, 16'h213);
    for (int i = 0; i < 7; i++) begin
      std_ev = 7'h40 >> i;
      @(negedge ref_clk);
      std_ev = '0;
      `CHK(err, err_w[i])
      `CHK(status_byte[STB_STD_BIT], 1'b1)
      do_cmd(SER_CMD_STD_EVQ, 16'h0, std_w[i]);
    end
    for (int i = 0; i < 4; i++) begin
      pin_pulse(4'h8 >> i);
      `CHK(status_byte[STB_QUESTIONABLE_SUMMARY_BIT_BIT], 1'b1)
      do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ, 16'h0, questionable_summary_bit_w[i]);
    end
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ, 16'h0, 16'h0);
    std_ev = 7'h02;
    @(negedge ref_clk);
    std_ev = '0;
    do_cmd(SER_CMD_RST, 16'h0, 16'h0);
    do_cmd(SER_CMD_DEV_CLR, 16'h0, 16'h0);
    do_cmd(SER_CMD_STD_EVQ, 16'h0, 16'h10);
    do_cmd(SER_CMD_STD_ENW, 16'h20, 16'h0);
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENW, 16'h10, 16'h0);
    std_ev = 7'h02;
    pin_pulse(4'h1);
    std_ev = '0;
    `CHK(status_byte, 8'h00)
    std_ev = 7'h01;
    @(negedge ref_clk);
    std_ev = '0;
    `CHK(status_byte, 8'h20)
    do_cmd(SER_CMD_STB_Q, 16'h0, 16'h20);
    do_cmd(SER_CMD_CLS, 16'h0, 16'h0);
    `CHK(status_byte, 8'h00)
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_EVQ, 16'h0, 16'h0);
    do_cmd(SER_CMD_STD_ENQ, 16'h0, 16'h20);
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENQ, 16'h0, 16'h10);
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENW, 16'h0, 16'h0);
    do_cmd(SER_CMD_QUESTIONABLE_SUMMARY_BIT_ENQ, 16'h0, 16'h0);
    do_cmd(SER_CMD_PSC_W, 16'h0, 16'h0);
    do_cmd(SER_CMD_PSC_Q, 16'h0, 16'h0);
    `CHK(power_on_clear_setting, 1'b0)
    do_reset(1'b0, 8'h11);
    do_cmd(SER_CMD_STD_ENQ, 16'h0, 16'h11);
    `CHK(std_mask_out, 8'h11)
    `CHK(power_on_clear_setting, 1'b0)
    do_cmd(SER_CMD_STD_EVQ, 16'h0, 16'h80);
    results();
  end
endmodule
`default_nettype wire
